// [vct_pkg.sv]
`default_nettype none
package vct_pkg;

  localparam int NREG = 10;

  localparam logic [7:0] ADDR_OBS_TUNE = 8'h39;
  localparam logic [7:0] ADDR_CONV_OFFSET = 8'h3a;
  localparam logic [7:0] ADDR_SD_RESET = 8'h3d;
  localparam logic [7:0] ADDR_CP_TEST = 8'h3e;
  localparam logic [7:0] ADDR_CLK1_LOW = 8'h3f;
  localparam logic [7:0] ADDR_CLK1_HIGH = 8'h40;
  localparam logic [7:0] ADDR_CLK2_LOW = 8'h41;
  localparam logic [7:0] ADDR_OSC_MUX = 8'h47;
  localparam logic [7:0] ADDR_OSC_BUF = 8'h52;
  localparam logic [7:0] ADDR_CNT_LOW = 8'h6e;
  localparam logic [7:0] ADDR_CNT_HIGH = 8'h6f;
  localparam logic [7:0] ADDR_DOUBLER = 8'h70;

  // index in the flip-flop array of each stored register that drives an output
  localparam int IDX_OBS_TUNE = 0;
  localparam int IDX_CONV_OFFSET = 1;
  localparam int IDX_CP_TEST = 3;
  localparam int IDX_DOUBLER = 9;

  localparam logic [7:0] REG_ADDR [0:NREG-1] = '{
    8'h39, 8'h3a, 8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h41, 8'h47, 8'h52, 8'h70};
  localparam logic [7:0] REG_RESET [0:NREG-1] = '{
    8'h07, 8'h55, 8'h00, 8'h0c, 8'h80, 8'h50, 8'h28, 8'hc0, 8'hf4, 8'h03};
  // writable bits; everything else is reserved and reads zero
  localparam logic [7:0] REG_WMASK [0:NREG-1] = '{
    8'h7f, 8'hff, 8'h40, 8'h0c, 8'hff, 8'h7f, 8'hff, 8'he0, 8'hfc, 8'he3};

  localparam int OBS_LSB = 4;
  localparam int OBS_W = 3;
  localparam int TUNE_LSB = 0;
  localparam int TUNE_W = 4;
  localparam int CP_LSB = 2;
  localparam int CP_W = 2;
  localparam int DBL_FILT_LSB = 5;
  localparam int DBL_FILT_W = 3;
  localparam int DBL_BIAS_LSB = 0;
  localparam int DBL_BIAS_W = 2;

  localparam logic [2:0] OBS_CAL_BUSY = 3'h0;
  localparam logic [2:0] OBS_RESERVED = 3'h3;
  localparam logic [2:0] OBS_LOW = 3'h7;

  localparam logic [3:0] TUNE_FLOOR_CODE = 4'h3;
  localparam logic [3:0] TUNE_CEIL_CODE = 4'hc;
  localparam logic [3:0] TUNE_TOP_STEP = 4'h9;

  localparam logic [1:0] CP_TRISTATE = 2'h0;
  localparam logic [1:0] CP_NORMAL = 2'h3;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } vct_req_t;

endpackage
`default_nettype wire

// [vct_regs.sv]
// Functional notes
// RL1: observe select routes internal signal to test output
// RL2: tuning code clamps low 0-3, high 12-15
// RL3: converter offset byte, read/write, resets 0x55
// RL4: charge pump select: 3 normal, 0 tristate
// RL5: counter readback split low/high, reset zero
// RL6: doubler filter select upper bits, reset zero
// RL7: doubler bias select low bits, reset three
// RL8: reserved bits read zero, ignore writes
`timescale 1ns/1ps
`default_nettype none
module vct_regs #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire vct_pkg::vct_req_t req,
  input wire logic [7:0] obsSrc,
  input wire logic counterLoad,
  input wire logic [CNT_W-1:0] counterIn,
  output logic [7:0] rdData_q,
  output logic rdValid_q,
  output logic testOut_q,
  output logic [3:0] tuningStep_q,
  output logic [3:0] tuningTargetCode_q,
  output logic [7:0] converterOffset_q,
  output logic [1:0] cpTestSelect_q,
  output logic cpTristate_q,
  output logic [2:0] doublerFilterSelect_q,
  output logic [1:0] doublerBiasSelect_q
);

  if (CNT_W < 9 || CNT_W > 16) begin : g_bad_width
    $error("CNT_W must lie between 9 and 16");
  end

  typedef struct packed {
    logic hit;
    logic [3:0] idx;
  } vct_lookup_t;

  function automatic vct_lookup_t lookup(input logic [7:0] addr);
    vct_lookup_t r;
    r = '0;
    for (int i = 0; i < vct_pkg::NREG; i++)
    begin
      if (vct_pkg::REG_ADDR[i] == addr)
      begin
        r.hit = 1'b1;
        r.idx = 4'(i);
      end
    end
    return r;
  endfunction

  // step 0 is the lowest target level, each code above the floor up to the ceiling code adds one
  function automatic logic [3:0] tuneStep(input logic [3:0] code);
    if (code <= vct_pkg::TUNE_FLOOR_CODE)
      return 4'h0;
    else if (code >= vct_pkg::TUNE_CEIL_CODE)
      return vct_pkg::TUNE_TOP_STEP;
    else
      return 4'(code - vct_pkg::TUNE_FLOOR_CODE);
  endfunction

  // derived from the reset code so the step and the code agree coming out of reset
  localparam logic [3:0] TUNE_STEP_RST =
    tuneStep(vct_pkg::REG_RESET[vct_pkg::IDX_OBS_TUNE][vct_pkg::TUNE_LSB +: vct_pkg::TUNE_W]);

  logic [7:0] regFile_q [0:vct_pkg::NREG-1];
  logic [7:0] regFile_d [0:vct_pkg::NREG-1];
  logic [15:0] counter_q;
  logic [15:0] counter_d;
  logic [7:0] rdData_d;
  logic rdValid_d;
  logic testOut_d;
  logic [3:0] tuningStep_d;
  logic cpTristate_d;
  logic [2:0] obsSel;
  logic [3:0] tuneCode;
  logic [1:0] cpSel;
  vct_lookup_t wrHit;
  vct_lookup_t rdHit;

  assign obsSel = regFile_q[vct_pkg::IDX_OBS_TUNE][vct_pkg::OBS_LSB +: vct_pkg::OBS_W];
  assign tuneCode = regFile_q[vct_pkg::IDX_OBS_TUNE][vct_pkg::TUNE_LSB +: vct_pkg::TUNE_W];
  assign cpSel = regFile_q[vct_pkg::IDX_CP_TEST][vct_pkg::CP_LSB +: vct_pkg::CP_W];
  assign wrHit = lookup(req.addr);
  assign rdHit = lookup(req.addr);

  always_comb
  begin
    for (int i = 0; i < vct_pkg::NREG; i++)
    begin
      regFile_d[i] = regFile_q[i];
    end
    // reserved bits never take the written value
    if (req.wr && wrHit.hit)
    begin
      regFile_d[wrHit.idx] = req.data & vct_pkg::REG_WMASK[wrHit.idx]; // RL3 RL6 RL7 RL8
    end
    // counter bytes are read-only; a write to them falls through here
    counter_d = counter_q;
    if (counterLoad)
    begin
      counter_d = 16'(counterIn); // RL5
    end
  end

  always_comb
  begin
    rdValid_d = req.rd;
    rdData_d = 8'h00;
    if (req.rd)
    begin
      if (rdHit.hit)
        rdData_d = regFile_q[rdHit.idx]; // RL8
      else if (req.addr == vct_pkg::ADDR_CNT_LOW)
        rdData_d = counter_q[7:0]; // RL5
      else if (req.addr == vct_pkg::ADDR_CNT_HIGH)
        rdData_d = counter_q[15:8]; // RL5
    end
  end

  always_comb
  begin
    // the reserved code is held low rather than exposing an unplanned node
    case (obsSel)
      vct_pkg::OBS_RESERVED: testOut_d = 1'b0;
      vct_pkg::OBS_LOW: testOut_d = 1'b0;
      default: testOut_d = obsSrc[obsSel]; // RL1
    endcase
    tuningStep_d = tuneStep(tuneCode); // RL2
    cpTristate_d = (cpSel == vct_pkg::CP_TRISTATE); // RL4
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < vct_pkg::NREG; i++)
      begin
        regFile_q[i] <= vct_pkg::REG_RESET[i];
      end
      counter_q <= 16'h0000;
      rdData_q <= 8'h00;
      rdValid_q <= 1'b0;
      testOut_q <= 1'b0;
      tuningStep_q <= TUNE_STEP_RST;
      cpTristate_q <= 1'b0;
    end
    else if (clkEn)
    begin
      for (int i = 0; i < vct_pkg::NREG; i++)
      begin
        regFile_q[i] <= regFile_d[i];
      end
      counter_q <= counter_d;
      rdData_q <= rdData_d;
      rdValid_q <= rdValid_d;
      testOut_q <= testOut_d;
      tuningStep_q <= tuningStep_d;
      cpTristate_q <= cpTristate_d;
    end
  end

  assign tuningTargetCode_q = tuneCode;
  assign converterOffset_q = regFile_q[vct_pkg::IDX_CONV_OFFSET];
  assign cpTestSelect_q = cpSel;
  assign doublerFilterSelect_q =
    regFile_q[vct_pkg::IDX_DOUBLER][vct_pkg::DBL_FILT_LSB +: vct_pkg::DBL_FILT_W];
  assign doublerBiasSelect_q =
    regFile_q[vct_pkg::IDX_DOUBLER][vct_pkg::DBL_BIAS_LSB +: vct_pkg::DBL_BIAS_W];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_obs_low_route: assert property (clkEn && obsSel == vct_pkg::OBS_LOW |=> !testOut_q) // RL1
    else $error("observe low select did not drive zero");
  a_obs_busy_route: assert property (clkEn && obsSel == vct_pkg::OBS_CAL_BUSY // RL1
    |=> testOut_q == $past(obsSrc[0]))
    else $error("busy select did not route source zero");
  a_tune_floor_clamp: assert property (clkEn && tuneCode <= vct_pkg::TUNE_FLOOR_CODE // RL2
    |=> tuningStep_q == 4'h0)
    else $error("low tuning codes not clamped");
  a_tune_ceil_clamp: assert property (clkEn && tuneCode >= vct_pkg::TUNE_CEIL_CODE // RL2
    |=> tuningStep_q == vct_pkg::TUNE_TOP_STEP)
    else $error("high tuning codes not clamped");
  a_offset_write_store: assert property (clkEn && req.wr // RL3
    && req.addr == vct_pkg::ADDR_CONV_OFFSET |=> converterOffset_q == $past(req.data))
    else $error("offset write not stored");
  // a write presented while the enable is low must leave no trace
  a_offset_freeze_hold: assert property (!clkEn |=> $stable(converterOffset_q)) // RL3
    else $error("offset changed while clock enable low");
  a_cp_tristate_flag: assert property (clkEn // RL4
    |=> cpTristate_q == ($past(cpSel) == vct_pkg::CP_TRISTATE))
    else $error("tristate flag wrong");
  a_cnt_low_read: assert property (clkEn && req.rd && req.addr == vct_pkg::ADDR_CNT_LOW // RL5
    |=> rdValid_q && rdData_q == $past(counter_q[7:0]))
    else $error("counter low byte readback wrong");
  a_cnt_high_read: assert property (clkEn && req.rd && req.addr == vct_pkg::ADDR_CNT_HIGH // RL5
    |=> rdValid_q && rdData_q == $past(counter_q[15:8]))
    else $error("counter high byte readback wrong");
  a_filter_write_store: assert property (clkEn && req.wr // RL6
    && req.addr == vct_pkg::ADDR_DOUBLER |=> doublerFilterSelect_q == $past(req.data[7:5]))
    else $error("filter select write not stored");
  a_bias_write_store: assert property (clkEn && req.wr // RL7
    && req.addr == vct_pkg::ADDR_DOUBLER |=> doublerBiasSelect_q == $past(req.data[1:0]))
    else $error("bias select write not stored");
  a_reserved_read_zero: assert property (clkEn && req.rd // RL8
    && req.addr == vct_pkg::ADDR_CP_TEST |=> rdData_q[7:4] == 4'h0 && rdData_q[1:0] == 2'h0)
    else $error("reserved bits read nonzero");
  a_unmapped_read_zero: assert property (clkEn && req.rd && !rdHit.hit // RL8
    && req.addr != vct_pkg::ADDR_CNT_LOW && req.addr != vct_pkg::ADDR_CNT_HIGH
    |=> rdValid_q && rdData_q == 8'h00)
    else $error("unmapped read returned nonzero data");

  c_cp_tristate: cover property (cpTristate_q ##1 !cpTristate_q);
  c_counter_read: cover property (rdValid_q
    ##1 (clkEn && req.rd && req.addr == vct_pkg::ADDR_CNT_LOW));
  c_tune_mid: cover property (tuningStep_q == 4'h5);
  c_frozen_write: cover property (!clkEn && req.wr);
  c_unmapped_read: cover property (clkEn && req.rd && !rdHit.hit
    && req.addr != vct_pkg::ADDR_CNT_LOW && req.addr != vct_pkg::ADDR_CNT_HIGH);

endmodule // vct_regs
`default_nettype wire

// [vct_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module vct_regs_tb;
  logic clk = 1'b0;
  logic rstN = 1'b0;
  logic clkEn = 1'b1;
  vct_pkg::vct_req_t req = '0;
  logic [7:0] obsSrc = 8'h00;
  logic counterLoad = 1'b0;
  logic [15:0] counterIn = 16'h0000;
  logic [7:0] rdData, offs;
  logic rdValid, testOut, cpTri;
  logic [3:0] step, code;
  logic [1:0] cpSel, bias;
  logic [2:0] filt;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  // 0x55 is unmapped; 0x6e/0x6f are counter readback
  logic [7:0] adr [13] = '{8'h39, 8'h3a, 8'h3d, 8'h3e, 8'h3f, 8'h40, 8'h41, 8'h47,
    8'h52, 8'h6e, 8'h6f, 8'h70, 8'h55};
  logic [7:0] rst [13] = '{8'h07, 8'h55, 8'h00, 8'h0c, 8'h80, 8'h50, 8'h28, 8'hc0,
    8'hf4, 8'h00, 8'h00, 8'h03, 8'h00};
  logic [7:0] msk [13] = '{8'h7f, 8'hff, 8'h40, 8'h0c, 8'hff, 8'h7f, 8'hff, 8'he0,
    8'hfc, 8'h00, 8'h00, 8'he3, 8'h00};

  vct_regs DUT (.clk(clk), .rst_n(rstN), .clkEn(clkEn), .req(req), .obsSrc(obsSrc),
    .counterLoad(counterLoad), .counterIn(counterIn), .rdData_q(rdData),
    .rdValid_q(rdValid), .testOut_q(testOut), .tuningStep_q(step),
    .tuningTargetCode_q(code), .converterOffset_q(offs), .cpTestSelect_q(cpSel),
    .cpTristate_q(cpTri), .doublerFilterSelect_q(filt), .doublerBiasSelect_q(bias));

  initial
  begin
    forever #10 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req.wr = 1'b1;
    req.addr = a;
    req.data = d;
    @(negedge clk);
    req = '0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    req = '0;
    chk("rdValid", rdValid, 1);
    chk($sformatf("read %h", a), rdData, exp);
  endtask

  task automatic testReset;
    for (int i = 0; i < 13; i++) rdchk(adr[i], rst[i]);
    chk("step", step, 4);
    chk("cpSel", cpSel, 3);
    chk("filt/bias", {filt, bias}, 5'h03);
    $display("reset test done");
  endtask

  task automatic testMask;
    for (int i = 0; i < 13; i++) wr(adr[i], 8'hff);
    chk("filt/bias", {filt, bias}, 5'h1f);
    for (int i = 0; i < 13; i++) rdchk(adr[i], msk[i]);
    for (int i = 0; i < 13; i++) wr(adr[i], 8'h00);
    for (int i = 0; i < 13; i++) rdchk(adr[i], 8'h00);
    $display("mask test done");
  endtask

  task automatic testFreeze;
    clkEn = 1'b0;
    wr(8'h3a, 8'h12);
    clkEn = 1'b1;
    chk("offs frozen", offs, 8'h00);
    wr(8'h3a, 8'ha6);
    chk("offs", offs, 8'ha6);
    $display("freeze test done");
  endtask

  task automatic testObs;
    for (int k = 0; k < 8; k++)
    begin
      wr(8'h39, {1'b0, 3'(k), 4'h7});
      obsSrc = 8'h01 << k;
      @(negedge clk);
      chk($sformatf("obs %0d", k), testOut, (k == 3 || k == 7) ? 1'b0 : 1'b1);
      obsSrc = ~(8'h01 << k);
      @(negedge clk);
      chk($sformatf("obs %0d low", k), testOut, 0);
    end
    $display("observe test done");
  endtask

  task automatic testTune;
    for (int c = 0; c < 16; c++)
    begin
      wr(8'h39, 8'(c));
      @(negedge clk);
      chk("code", code, 16'(c));
      chk("step", step, (c < 4) ? 0 : (c > 12) ? 9 : 16'(c - 3));
    end
    $display("tuning test done");
  endtask

  task automatic testCp;
    logic [7:0] v [3] = '{8'h00, 8'h04, 8'h0c};
    for (int i = 0; i < 3; i++)
    begin
      wr(8'h3e, v[i]);
      @(negedge clk);
      chk("cpSel", cpSel, 16'(v[i][3:2]));
      chk("cpTri", cpTri, (i == 0) ? 1'b1 : 1'b0);
    end
    $display("charge pump test done");
  endtask

  task automatic testCounter;
    @(negedge clk);
    counterIn = 16'ha5c3;
    counterLoad = 1'b1;
    @(negedge clk);
    counterLoad = 1'b0;
    counterIn = 16'h5a3c;
    rdchk(8'h6e, 8'hc3);
    rdchk(8'h6f, 8'ha5);
    @(negedge clk);
    chk("rdValid idle", rdValid, 0);
    chk("rdData idle", rdData, 0);
    $display("counter test done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // generous ceiling; the whole sequence needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      results();
    end
  end

  initial
  begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rstN = 1'b1;
    testReset();
    testMask();
    testFreeze();
    testObs();
    testTune();
    testCp();
    testCounter();
    results();
  end
endmodule // vct_regs_tb
`default_nettype wire
